// File: chan_port_defines.svh
// Constants of the channel control and status byte port
`ifndef CHAN_PORT_DEFINES_SVH
`define CHAN_PORT_DEFINES_SVH
`define MODE_BIT        7
`define DIR_BIT         6
`define CAL_EN_BIT      5
`define CAL_GAIN_BIT    4
`define CAL_OFFS_BIT    3
`define CLK_SEL_BIT     2
`define ADJ_UP_BIT      1
`define ADJ_DOWN_BIT    0
`define ERR_BIT         6
`define OVER_BIT        1
`define UNDER_BIT       0
`define REG_NUM_W       6
`define REG_CODE_WORD   6'h1f
`define REG_DIAG        6'h06
`define USER_REG_FIRST  6'h10
`define USER_CODE       16'h1235
`define REG_RESET       16'h0000
`define STATUS_RESET    8'h00
`endif

// File: chan_port_pkg.sv
// Types shared by the channel port files
package chan_port_pkg;
   // Calibration controls decoded from the control byte
   typedef struct packed {
      logic enable;
      logic gain;
      logic offset;
      logic fast_clock;
      logic up;
      logic down;
   } cal_ctrl_s;
   // Register access request towards the register store
   typedef struct packed {
      logic       valid;
      logic       write;
      logic [5:0] number;
      logic [15:0] data;
   } reg_req_s;
   // Measurement flags from the conversion path
   typedef struct packed {
      logic error;
      logic over;
      logic under;
   } meas_flags_s;
endpackage

// File: channel_port.sv
// One channel: control byte decode, status byte and register store
`timescale 1ns/100ps
`default_nettype none
`include "chan_port_defines.svh"
module channel_port #(
   parameter int NUM_REGS = 64
) (
   // Clock and reset
   input  wire logic                     clk_sys,
   input  wire logic                     rst_n,
   // Process image
   input  wire logic [7:0]               channel_control_byte,
   input  wire logic [15:0]              output_data_word,
   input  wire logic [15:0]              meas_value,
   input  wire chan_port_pkg::meas_flags_s flags,
   output logic      [7:0]               channel_status_byte,
   output logic      [15:0]              input_data_word,
   // Calibration towards the conversion path
   output chan_port_pkg::cal_ctrl_s      cal_ctrl,
   output logic                          cal_commit
);
   import chan_port_pkg::*;

   logic [15:0] regs_r [NUM_REGS];
   logic [7:0]  status_r;
   logic [15:0] data_r;
   logic [15:0] code_r;
   logic        code_ok;
   logic        reg_mode;
   reg_req_s    req;
   logic        user_reg;
   logic [7:0]  pd_byte;

   // Mode bit chooses how the rest of the byte is read
   assign reg_mode = channel_control_byte[`MODE_BIT];
   assign code_ok  = (code_r == `USER_CODE);
   assign req.valid  = reg_mode;
   assign req.write  = channel_control_byte[`DIR_BIT];
   assign req.number = channel_control_byte[`REG_NUM_W-1:0];
   assign req.data   = output_data_word;
   assign user_reg   = (req.number >= `USER_REG_FIRST) &&
                       (req.number != `REG_CODE_WORD);

   // Process data view of the byte; zero in register mode so that
   // register numbers never reach the calibration controls
   assign pd_byte = reg_mode ? '0 : channel_control_byte;

   // Code word cleared at restart, written without the code word check that user registers need
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         code_r <= `REG_RESET;
      end else if (req.valid && req.write &&
                   req.number == `REG_CODE_WORD) begin
         code_r <= req.data;
      end
   end

   // User registers only take data once the code word is present
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_r[i] <= `REG_RESET;
         end
      end else if (req.valid && req.write && user_reg && code_ok) begin
         regs_r[req.number] <= req.data;
      end
   end

   // Status byte and data word, registered
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         status_r <= `STATUS_RESET;
         data_r   <= `REG_RESET;
      end else if (reg_mode) begin
         status_r <= {1'b1, req.write, req.number};
         if (req.number == `REG_CODE_WORD) begin
            data_r <= code_r;
         end else if (req.number == `REG_DIAG) begin
            data_r <= {8'h00, status_r};
         end else begin
            data_r <= regs_r[req.number];
         end
      end else begin
         // Reserved bits 5..2 forced low
         status_r <= {1'b0, flags.error, 4'h0,
                      flags.over, flags.under};
         data_r   <= meas_value;
      end
   end

   // Calibration enable only sets with the code word in place; the other controls follow the byte regardless
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cal_ctrl <= '0;
      end else begin
         cal_ctrl.enable <= code_ok && pd_byte[`CAL_EN_BIT];
         cal_ctrl.gain   <= pd_byte[`CAL_GAIN_BIT];
         cal_ctrl.offset <= pd_byte[`CAL_OFFS_BIT];
         cal_ctrl.fast_clock <= pd_byte[`CLK_SEL_BIT];
         cal_ctrl.up     <= pd_byte[`ADJ_UP_BIT];
         cal_ctrl.down   <= pd_byte[`ADJ_DOWN_BIT];
      end
   end

   // Commit pulse when a register write takes the code word away: value stored for good
   logic code_ok_d;
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         code_ok_d  <= 1'b0;
         cal_commit <= 1'b0;
      end else begin
         code_ok_d  <= code_ok;
         cal_commit <= code_ok_d && !code_ok;
      end
   end

   assign channel_status_byte = status_r;
   assign input_data_word     = data_r;
endmodule
`default_nettype wire

// File: chan_ctrl_status_port.sv
// Two-channel control and status byte port
//
// Summary of operation
// - Control byte comes in output image; status byte goes in input image.
// - Control bit 7 picks process data mode (0) or register mode (1).
// - Status bit 7 acknowledges the active mode.
// - Control bit 5 enables compensation, only with code word present.
// - Bits 4/3 select gain/offset; storage commits when a write clears the code word.
// - Bit 2 slow/fast clock, bit 1 up, bit 0 down; bit 6 reserved.
// - Status bit 6 is general error; bits 5..2 read zero.
// - Status bit 1 over range, bit 0 under range.
// - In register mode control bit 6: 0 read, 1 write.
// - Bits 5..0 give register number; data words carry the value.
// - Status bit 6 echoes access direction, 0 for read.
// - Second channel identical and independent.
// - User register writes refused without the user code word.
// - Code word register clears on restart.
// - Diagnostic register low byte shows the status byte.
`timescale 1ns/100ps
`default_nettype none
`include "chan_port_defines.svh"
module chan_ctrl_status_port #(
   parameter int NUM_CHANNELS = 2,
   parameter int NUM_REGS     = 64
) (
   // Clock and reset
   input  wire logic                        clk_sys,
   input  wire logic                        rst_n,
   // Output image from the controller
   input  wire logic [NUM_CHANNELS-1:0][7:0]  control_bytes,
   input  wire logic [NUM_CHANNELS-1:0][15:0] output_data_words,
   // Conversion path results
   input  wire logic [NUM_CHANNELS-1:0][15:0] meas_values,
   input  wire chan_port_pkg::meas_flags_s [NUM_CHANNELS-1:0] meas_flags,
   // Input image to the controller
   output logic      [NUM_CHANNELS-1:0][7:0]  status_bytes,
   output logic      [NUM_CHANNELS-1:0][15:0] input_data_words,
   // Calibration controls
   output chan_port_pkg::cal_ctrl_s [NUM_CHANNELS-1:0] cal_ctrls,
   output logic      [NUM_CHANNELS-1:0]       cal_commits
);
   import chan_port_pkg::*;

   // Each channel owns its bytes and register store
   for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_ch
      channel_port #(.NUM_REGS(NUM_REGS)) u_ch (
         .clk_sys              (clk_sys),
         .rst_n                (rst_n),
         .channel_control_byte (control_bytes[c]),
         .output_data_word     (output_data_words[c]),
         .meas_value           (meas_values[c]),
         .flags                (meas_flags[c]),
         .channel_status_byte  (status_bytes[c]),
         .input_data_word      (input_data_words[c]),
         .cal_ctrl             (cal_ctrls[c]),
         .cal_commit           (cal_commits[c])
      );
   end
endmodule
`default_nettype wire

// File: chan_ctrl_status_port_sva.sv
// Assertions bound to the two-channel control and status port
`timescale 1ns/100ps
`default_nettype none
module chan_ctrl_status_port_sva
   import chan_port_pkg::*;
#(parameter int NUM_CHANNELS = 2) (
   input wire logic                         clk_sys,
   input wire logic                         rst_n,
   input wire logic [NUM_CHANNELS-1:0][7:0] control_bytes,
   input wire meas_flags_s [NUM_CHANNELS-1:0] meas_flags,
   input wire logic [NUM_CHANNELS-1:0][7:0] status_bytes,
   input wire logic [NUM_CHANNELS-1:0]      cal_commits
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire logic [7:0] c0 = control_bytes[0], s0 = status_bytes[0];
   wire logic [7:0] c1 = control_bytes[1], s1 = status_bytes[1];
   property p_ack; 1 |=> s0[7] == $past(c0[7]); endproperty
   a_ack: assert property (p_ack) else $error("mode ack");
   property p_err; !c0[7] |=> s0[6] == $past(meas_flags[0].error); endproperty
   a_err: assert property (p_err) else $error("error bit");
   property p_rsv; !c0[7] |=> s0[5:2] == 4'h0; endproperty
   a_rsv: assert property (p_rsv) else $error("reserved bits");
   property p_ovr; !c0[7] |=> s0[1] == $past(meas_flags[0].over); endproperty
   a_ovr: assert property (p_ovr) else $error("over range");
   property p_und; !c0[7] |=> s0[0] == $past(meas_flags[0].under); endproperty
   a_und: assert property (p_und) else $error("under range");
   property p_echo; c0[7] |=> s0[6:0] == $past(c0[6:0]); endproperty
   a_echo: assert property (p_echo) else $error("echo");
   property p_ch2; c1[7] |=> s1 == $past(c1); endproperty
   a_ch2: assert property (p_ch2) else $error("second channel");
   property p_pul; cal_commits[0] |=> !cal_commits[0]; endproperty
   a_pul: assert property (p_pul) else $error("commit pulse");
endmodule
bind chan_ctrl_status_port chan_ctrl_status_port_sva #(.NUM_CHANNELS(2)) u_sva (
   .clk_sys(clk_sys), .rst_n(rst_n), .control_bytes(control_bytes),
   .meas_flags(meas_flags), .status_bytes(status_bytes),
   .cal_commits(cal_commits));
`default_nettype wire

// File: fieldbus_ctrl_model.sv
// Controller model driving the first channel's output image
`timescale 1ns/100ps
`default_nettype none
module fieldbus_ctrl_model (
   // Clock and bench request
   input  wire logic        clk_sys,
   input  wire logic [7:0]  cmd,
   input  wire logic [15:0] wdata,
   // Output image
   output logic      [7:0]  control = 8'h00,
   output logic      [15:0] dout = 16'h0000
);
   // Data only stands during a write, so stale words cannot pass
   always @(negedge clk_sys) begin
      control <= cmd;
      dout <= (cmd[7] && cmd[6]) ? wdata : ~dout;
   end
endmodule
`default_nettype wire

// File: chan_ctrl_status_port_tb_top.sv
// Self-checking bench for the two-channel control and status port
`timescale 1ns/100ps
`default_nettype none
module chan_ctrl_status_port_tb_top;
   logic        clk_sys = 0, rst_n = 0;
   logic [1:0]  cp;
   logic [5:0]  mf = 0;
   logic [7:0]  cmd = 0, ctrl0;
   logic [11:0] cc;
   logic [15:0] wdata = 0, dout0, sb;
   logic [31:0] vals = 0, idw;
   int          errors = 0, samples_checked = 0;
   // Free-running clock
   always #5 clk_sys = ~clk_sys;
   chan_ctrl_status_port dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .control_bytes({8'h85, ctrl0}), .output_data_words({16'h0, dout0}),
      .meas_values(vals), .meas_flags(mf), .status_bytes(sb),
      .input_data_words(idw), .cal_ctrls(cc), .cal_commits(cp));
   fieldbus_ctrl_model ctl (.clk_sys(clk_sys), .cmd(cmd), .wdata(wdata),
      .control(ctrl0), .dout(dout0));
   task automatic check(string nm, logic [15:0] exp, logic [15:0] got);
      samples_checked++;
      if (got !== exp) errors++;
      if (got !== exp) $display("wrong value %s %h %h", nm, exp, got);
   endtask
   // Hold each byte until the echo has settled, then judge read data
   // Request is set after a rising edge so the model takes it at the
   // next falling edge without a race
   task automatic acc(logic [7:0] c, logic [15:0] w, logic [15:0] exp);
      @(posedge clk_sys);
      cmd = c;
      wdata = w;
      repeat (3) @(negedge clk_sys);
      if (!c[6]) check("data", exp, idw[15:0]);
      if (c[7]) check("status", {8'h00, c}, {8'h00, sb[7:0]});
   endtask
   task automatic finish_test;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic t_proc;
      for (int f = 0; f < 8; f++) begin
         mf[2:0] = f[2:0];
         vals[15:0] = 16'h1000 + 16'(f);
         acc(8'h00, 16'h0, vals[15:0]);
         check("status", {9'h000, f[2], 4'h0, f[1:0]}, {8'h00, sb[7:0]});
      end
   endtask
   // Locked write, code word, accepted write, calibration, commit
   task automatic t_regs;
      acc(8'h9f, 16'h0, 16'h0);
      acc(8'hd0, 16'habcd, 16'h0);
      acc(8'h90, 16'h0, 16'h0);
      acc(8'hdf, 16'h1235, 16'h0);
      acc(8'hd0, 16'habcd, 16'h0);
      acc(8'h90, 16'h0, 16'habcd);
      acc(8'h3d, 16'h0, vals[15:0]);
      check("cal", 16'h3d, {10'h0, cc[5:0]});
      acc(8'hdf, 16'h0, 16'h0);
      check("commit", 16'h1, {15'h0, cp[0]});
      @(negedge clk_sys);
      check("commit end", 16'h0, {15'h0, cp[0]});
      acc(8'h3d, 16'h0, vals[15:0]);
      check("cal locked", 16'h1d, {10'h0, cc[5:0]});
      check("status 2", 16'h0085, {8'h00, sb[15:8]});
      check("data 2", 16'h0, idw[31:16]);
   endtask
   // Code word present, then a restart in mid-run must clear it
   task automatic t_restart;
      acc(8'hdf, 16'h1235, 16'h0);
      acc(8'h9f, 16'h0, 16'h1235);
      rst_n = 0;
      @(posedge clk_sys);
      cmd = 8'h9f;
      repeat (2) @(negedge clk_sys);
      check("reset status", 16'h0, {8'h00, sb[7:0]});
      rst_n = 1;
      acc(8'h9f, 16'h0, 16'h0);
   endtask
   initial begin
      repeat (5) @(negedge clk_sys);
      rst_n = 1;
      t_proc();
      t_regs();
      t_restart();
      finish_test();
   end
   initial begin
      #20000;
      errors++;
      finish_test();
   end
endmodule
`default_nettype wire
